// *** rtl/dbes_top.sv ***
// top of the dual buck enable and fault sequencer
`timescale 1ns/100ps
module dbes_top #(
  parameter bit          ALWAYS_ON_5V = 1'b0,
  parameter int unsigned PG_DELAY     = dbes_pkg::PG_DELAY_CYC,
  parameter int unsigned UV_FILT      = dbes_pkg::UV_FILT_CYC,
  parameter int unsigned UV_MASK      = dbes_pkg::UV_MASK_CYC,
  parameter int unsigned SS_STEP      = dbes_pkg::SS_STEP_CYC,
  parameter int unsigned PUMP_HALF    = dbes_pkg::PUMP_HALF_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic       ch1_enable_i,
  input  wire logic       ch2_enable_i,
  input  wire logic       vin_above_uvlo_i,
  input  wire logic       ldo_3v3_above_2v4_i,
  input  wire logic       ldo_3v3_above_uvlo_i,
  input  wire logic       ldo_5v_above_uvlo_i,
  input  wire logic       over_temp_i,
  input  wire logic       ch1_over_i,
  input  wire logic       ch2_over_i,
  input  wire logic       ch1_above_pg_i,
  input  wire logic       ch2_above_pg_i,
  input  wire logic       ch1_under_i,
  input  wire logic       ch2_under_i,
  input  wire logic       ch1_fb_zero_i,
  input  wire logic       ch2_fb_zero_i,
  input  wire logic       ch1_ocl_i,
  input  wire logic       ch2_ocl_i,
  input  wire logic       ch1_neg_ocl_i,
  input  wire logic       ch2_neg_ocl_i,
  input  wire logic       ch1_ontime_done_i,
  input  wire logic       ch2_ontime_done_i,
  input  wire logic       ch1_pwm_req_i,
  input  wire logic       ch2_pwm_req_i,
  input  wire logic       ch1_out_above_sw_i,
  output logic            ldo_3v3_en_o,
  output logic            ldo_5v_en_o,
  output logic            switchover_o,
  output logic            ldo_3v3_from_ch1_o,
  output logic            pump_clock_out_o,
  output logic            power_good_out_o,
  output logic            ch1_output_sense_dis_o,
  output logic            ch2_switch_node_dis_o,
  output logic            ch1_high_side_gate_o,
  output logic            ch1_low_side_gate_o,
  output logic            ch2_high_side_gate_o,
  output logic            ch2_low_side_gate_o,
  output logic [9:0]      ch1_ref_code_o,
  output logic [9:0]      ch2_ref_code_o
);
  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  rst_sync_reg;
  logic        rst_b;
  logic [25:0] pin_raw;
  logic [25:0] pin;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  assign pin_raw = {ch1_enable_i, ch2_enable_i, vin_above_uvlo_i, ldo_3v3_above_2v4_i,
                    ldo_3v3_above_uvlo_i, ldo_5v_above_uvlo_i, over_temp_i,
                    ch1_over_i, ch2_over_i, ch1_above_pg_i, ch2_above_pg_i,
                    ch1_under_i, ch2_under_i, ch1_fb_zero_i, ch2_fb_zero_i,
                    ch1_ocl_i, ch2_ocl_i, ch1_neg_ocl_i, ch2_neg_ocl_i,
                    ch1_ontime_done_i, ch2_ontime_done_i, ch1_pwm_req_i,
                    ch2_pwm_req_i, ch1_out_above_sw_i, 2'h0};

  dbes_sync #(
    .W(26)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b),
    .d_i       (pin_raw),
    .q_o       (pin)
  );

  logic en1, en2, vin_ok, v3_2v4, v3_ok, v5_ok, hot;
  logic ov1, ov2, pg1, pg2, un1, un2, z1, z2, oc1, oc2, noc1, noc2;
  logic ot1, ot2, rq1, rq2, sw_ok;
  assign {en1, en2, vin_ok, v3_2v4, v3_ok, v5_ok, hot, ov1, ov2, pg1, pg2,
          un1, un2, z1, z2, oc1, oc2, noc1, noc2, ot1, ot2, rq1, rq2, sw_ok}
         = pin[25:2];

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic       run_ok;
  logic [9:0] r1, r2;
  logic       h1, l1, h2, l2;
  logic       ovp1, ovp2, uvp1, uvp2, rmp1, rmp2, act1, act2;

  assign run_ok = vin_ok && v5_ok && v3_ok && !hot;

  dbes_channel #(
    .UV_FILT (UV_FILT),
    .UV_MASK (UV_MASK),
    .SS_STEP (SS_STEP)
  ) u_ch1 (
    .ref_clk_i        (ref_clk_i),
    .rst_b_i          (rst_b),
    .ce_i             (ce_i),
    .enable_i         (en1),
    .run_ok_i         (run_ok),
    .ocl_i            (oc1),
    .neg_ocl_i        (noc1),
    .ontime_done_i    (ot1),
    .fb_over_i        (ov1),
    .fb_under_i       (un1),
    .fb_zero_i        (z1),
    .pwm_on_req_i     (rq1),
    .ref_code_o       (r1),
    .high_side_gate_o (h1),
    .low_side_gate_o  (l1),
    .ovp_o            (ovp1),
    .uvp_o            (uvp1),
    .ramped_o         (rmp1),
    .active_o         (act1)
  );

  dbes_channel #(
    .UV_FILT (UV_FILT),
    .UV_MASK (UV_MASK),
    .SS_STEP (SS_STEP)
  ) u_ch2 (
    .ref_clk_i        (ref_clk_i),
    .rst_b_i          (rst_b),
    .ce_i             (ce_i),
    .enable_i         (en2),
    .run_ok_i         (run_ok),
    .ocl_i            (oc2),
    .neg_ocl_i        (noc2),
    .ontime_done_i    (ot2),
    .fb_over_i        (ov2),
    .fb_under_i       (un2),
    .fb_zero_i        (z2),
    .pwm_on_req_i     (rq2),
    .ref_code_o       (r2),
    .high_side_gate_o (h2),
    .low_side_gate_o  (l2),
    .ovp_o            (ovp2),
    .uvp_o            (uvp2),
    .ramped_o         (rmp2),
    .active_o         (act2)
  );

  // ----------------------------------------------------------------
  // sequencing, power-good and pump clock state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       v3;
    logic       v5;
    logic       swo;
    logic       pump;
    logic [9:0] pump_cnt;
    logic       pg;
    logic [19:0] pg_cnt;
    logic       dis1;
    logic       dis2;
    logic       h1;
    logic       l1;
    logic       h2;
    logic       l2;
    logic [9:0] r1;
    logic [9:0] r2;
  } dbes_top_t;

  dbes_top_t s_reg;
  dbes_top_t s_next;
  logic      pg_ok;
  logic      any_uvp;

  assign any_uvp = uvp1 || uvp2;
  assign pg_ok   = en1 && en2 && rmp1 && rmp2 && pg1 && pg2
                   && !ov1 && !ov2 && !un1 && !un2;

  always_comb begin
    s_next = s_reg;
    s_next.v3 = vin_ok && !hot;
    if (ALWAYS_ON_5V) begin
      s_next.v5 = s_reg.v3 && v3_2v4 && !hot;
    end else begin
      s_next.v5 = s_reg.v3 && v3_2v4 && !hot && (en1 || en2);
    end
    s_next.swo = s_next.v5 && act1 && !ovp1 && !uvp1 && !oc1 && sw_ok;
    // pump clock divider
    if (en1 && !hot) begin
      if (s_reg.pump_cnt >= 10'(PUMP_HALF - 1)) begin
        s_next.pump_cnt = '0;
        s_next.pump     = !s_reg.pump;
      end else begin
        s_next.pump_cnt = s_reg.pump_cnt + 10'h001;
      end
    end else begin
      s_next.pump_cnt = '0;
      s_next.pump     = 1'b0;
    end
    // power-good delay
    if (!pg_ok) begin
      s_next.pg_cnt = '0;
      s_next.pg     = 1'b0;
    end else if (s_reg.pg_cnt >= 20'(PG_DELAY - 1)) begin
      s_next.pg = 1'b1;
    end else begin
      s_next.pg_cnt = s_reg.pg_cnt + 20'h00001;
    end
    s_next.dis1 = !en1 || any_uvp;
    s_next.dis2 = !en2 || any_uvp;
    s_next.h1   = h1 && !any_uvp;
    s_next.l1   = l1 && !any_uvp;
    s_next.h2   = h2 && !any_uvp;
    s_next.l2   = l2 && !any_uvp;
    s_next.r1   = r1;
    s_next.r2   = r2;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ldo_3v3_en_o           = s_reg.v3;
  assign ldo_5v_en_o            = s_reg.v5 && !s_reg.swo;
  assign switchover_o           = s_reg.swo;
  assign ldo_3v3_from_ch1_o     = s_reg.swo;
  assign pump_clock_out_o       = s_reg.pump;
  assign power_good_out_o       = s_reg.pg;
  assign ch1_output_sense_dis_o = s_reg.dis1;
  assign ch2_switch_node_dis_o  = s_reg.dis2;
  assign ch1_high_side_gate_o   = s_reg.h1;
  assign ch1_low_side_gate_o    = s_reg.l1;
  assign ch2_high_side_gate_o   = s_reg.h2;
  assign ch2_low_side_gate_o    = s_reg.l2;
  assign ch1_ref_code_o         = s_reg.r1;
  assign ch2_ref_code_o         = s_reg.r2;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PG_NEEDS_EN: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    power_good_out_o |-> en1 && en2) else $error("power good without both enables");
  AST_PG_OV_DROP: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    ce_i && ov1 |=> !power_good_out_o) else $error("power good held during overvoltage");
  AST_PG_UV_DROP: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    ce_i && un2 |=> !power_good_out_o) else $error("power good held during undervoltage");
  AST_PUMP_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    !en1 && ce_i |=> !pump_clock_out_o) else $error("pump clock runs with ch1 off");
  AST_V5_VARIANT: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    ce_i && !ALWAYS_ON_5V && !en1 && !en2 |=> !s_reg.v5) else $error("5V on without enable");
  AST_SWO_LDO: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    switchover_o |-> !ldo_5v_en_o && ldo_3v3_from_ch1_o) else $error("switchover not exclusive");
  AST_UV_GATES: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    ce_i && any_uvp |=> !ch1_high_side_gate_o && !ch1_low_side_gate_o
    && ch1_output_sense_dis_o && ch2_switch_node_dis_o) else $error("uv latch not enforced");
  AST_HOT_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    ce_i && hot |=> !ldo_3v3_en_o) else $error("regulator on while hot");
  AST_PG_DELAY: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    $rose(power_good_out_o) |-> $past(pg_ok)) else $error("power good rose without cause");
endmodule

// *** rtl/dbes_pkg.sv ***
// constants and types of the dual buck enable and fault sequencer
package dbes_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  // pump clock
  localparam int unsigned PUMP_HZ        = 256_000;
  localparam int unsigned PUMP_HALF_CYC  = CLK_HZ / (2 * PUMP_HZ);
  // soft-start ramp
  localparam int unsigned SS_TIME_NS     = 800_000;
  localparam int unsigned SS_CYC         = SS_TIME_NS / 4;
  // reference target code (2 V full scale)
  localparam int unsigned REF_W          = 10;
  localparam logic [9:0]  REF_TARGET     = 10'h3ff;
  localparam int unsigned SS_STEP_CYC    = SS_CYC / 1023;
  // undervoltage filter (least time, round up)
  localparam int unsigned UV_FILT_NS     = 250_000;
  localparam int unsigned UV_FILT_CYC    = (UV_FILT_NS + 3) / 4;
  // undervoltage mask after start-up
  localparam int unsigned UV_MASK_NS     = 1_100_000;
  localparam int unsigned UV_MASK_CYC    = (UV_MASK_NS + 3) / 4;
  // power-good delay in timebase cycles
  localparam int unsigned PG_DELAY_CYC   = 1024;
  localparam int unsigned CNT_W          = 20;
  // channel states
  typedef enum logic [2:0] {
    DBES_CH_OFF  = 3'b000,
    DBES_CH_RAMP = 3'b001,
    DBES_CH_RUN  = 3'b010,
    DBES_CH_OVP  = 3'b011,
    DBES_CH_OVL  = 3'b100,
    DBES_CH_UVL  = 3'b101
  } dbes_ch_state_t;
endpackage

// *** rtl/dbes_sync.sv ***
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module dbes_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// *** rtl/dbes_channel.sv ***
// one switching channel: soft-start, protection latches, driver control
`timescale 1ns/100ps
module dbes_channel #(
  parameter int unsigned UV_FILT  = dbes_pkg::UV_FILT_CYC,
  parameter int unsigned UV_MASK  = dbes_pkg::UV_MASK_CYC,
  parameter int unsigned SS_STEP  = dbes_pkg::SS_STEP_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic       enable_i,
  input  wire logic       run_ok_i,
  input  wire logic       ocl_i,
  input  wire logic       neg_ocl_i,
  input  wire logic       ontime_done_i,
  input  wire logic       fb_over_i,
  input  wire logic       fb_under_i,
  input  wire logic       fb_zero_i,
  input  wire logic       pwm_on_req_i,
  output logic [9:0]      ref_code_o,
  output logic            high_side_gate_o,
  output logic            low_side_gate_o,
  output logic            ovp_o,
  output logic            uvp_o,
  output logic            ramped_o,
  output logic            active_o
);
  typedef struct packed {
    dbes_pkg::dbes_ch_state_t st;
    logic [9:0]               refc;
    logic [19:0]              ss_cnt;
    logic [19:0]              uv_cnt;
    logic [19:0]              mask_cnt;
    logic                     hs;
    logic                     ls;
  } dbes_ch_t;

  dbes_ch_t s_reg;
  dbes_ch_t s_next;

  always_comb begin
    s_next = s_reg;
    if (!enable_i) begin
      s_next = '0;
    end else begin
      unique case (s_reg.st)
        dbes_pkg::DBES_CH_OFF: begin
          if (run_ok_i) begin
            s_next.st = dbes_pkg::DBES_CH_RAMP;
          end
        end
        dbes_pkg::DBES_CH_RAMP, dbes_pkg::DBES_CH_RUN: begin
          // ramp the reference step by step
          if (s_reg.refc != dbes_pkg::REF_TARGET) begin
            if (s_reg.ss_cnt >= 20'(SS_STEP - 1)) begin
              s_next.ss_cnt = '0;
              s_next.refc   = s_reg.refc + 10'h001;
            end else begin
              s_next.ss_cnt = s_reg.ss_cnt + 20'h00001;
            end
          end else begin
            s_next.st = dbes_pkg::DBES_CH_RUN;
          end
          if (s_reg.mask_cnt < 20'(UV_MASK)) begin
            s_next.mask_cnt = s_reg.mask_cnt + 20'h00001;
          end
          // undervoltage filter
          if (fb_under_i && s_reg.mask_cnt >= 20'(UV_MASK)) begin
            s_next.uv_cnt = s_reg.uv_cnt + 20'h00001;
          end else begin
            s_next.uv_cnt = '0;
          end
          // pwm: off state held while current above limit
          if (s_reg.hs && ontime_done_i) begin
            s_next.hs = 1'b0;
            s_next.ls = 1'b1;
          end else if (!s_reg.hs && pwm_on_req_i && !ocl_i) begin
            s_next.hs = 1'b1;
            s_next.ls = 1'b0;
          end
          if (!run_ok_i) begin
            s_next    = '0;
          end else if (fb_over_i) begin
            s_next.st   = dbes_pkg::DBES_CH_OVP;
            s_next.refc = '0;
            s_next.hs   = 1'b0;
            s_next.ls   = 1'b1;
          end else if (s_reg.uv_cnt >= 20'(UV_FILT - 1) && fb_under_i
                       && s_reg.mask_cnt >= 20'(UV_MASK)) begin
            s_next.st = dbes_pkg::DBES_CH_UVL;
            s_next.hs = 1'b0;
            s_next.ls = 1'b0;
          end
        end
        dbes_pkg::DBES_CH_OVP: begin
          // alternate low-side and on-time pulses down to zero
          if (fb_zero_i) begin
            s_next.st = dbes_pkg::DBES_CH_OVL;
            s_next.hs = 1'b0;
            s_next.ls = 1'b1;
          end else if (s_reg.ls && neg_ocl_i) begin
            s_next.hs = 1'b1;
            s_next.ls = 1'b0;
          end else if (s_reg.hs && ontime_done_i) begin
            s_next.hs = 1'b0;
            s_next.ls = 1'b1;
          end
        end
        dbes_pkg::DBES_CH_OVL: begin
          s_next.hs = 1'b0;
          s_next.ls = 1'b1;
        end
        dbes_pkg::DBES_CH_UVL: begin
          s_next.hs = 1'b0;
          s_next.ls = 1'b0;
        end
        default: begin
          s_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign ref_code_o       = s_reg.refc;
  assign high_side_gate_o = s_reg.hs;
  assign low_side_gate_o  = s_reg.ls;
  assign ovp_o    = (s_reg.st == dbes_pkg::DBES_CH_OVP) || (s_reg.st == dbes_pkg::DBES_CH_OVL);
  assign uvp_o    = (s_reg.st == dbes_pkg::DBES_CH_UVL);
  assign ramped_o = (s_reg.st == dbes_pkg::DBES_CH_RUN);
  assign active_o = (s_reg.st == dbes_pkg::DBES_CH_RAMP) || (s_reg.st == dbes_pkg::DBES_CH_RUN);
endmodule

// *** verification/dbes_host_model.sv ***
// host enable logic and power-good monitor facing the sequencer
`timescale 1ns/100ps
module dbes_host_model (
  input  wire logic ref_clk_i,
  input  wire logic en1_req_i,
  input  wire logic en2_req_i,
  input  wire logic recover_i,
  input  wire logic power_good_i,
  output logic      ch1_enable_o,
  output logic      ch2_enable_o,
  output logic      pg_seen_o
);
  // the pump clock pin load is assumed absent: the pump clock is in use
  initial begin
    ch1_enable_o = 1'b0;
    ch2_enable_o = 1'b0;
    pg_seen_o    = 1'b0;
  end
  // enables change on the falling edge; recover drops both to clear latches
  always @(negedge ref_clk_i) begin
    ch1_enable_o <= en1_req_i & ~recover_i;
    ch2_enable_o <= en2_req_i & ~recover_i;
    pg_seen_o    <= pg_seen_o | power_good_i;
  end
endmodule

// *** verification/test_dual_buck_enable_fault_sequencer.sv ***
// self-checking bench of the dual buck enable and fault sequencer
`timescale 1ns/100ps
module test_dual_buck_enable_fault_sequencer;
  logic       ref_clk, rst_b, ce, en1_req, en2_req, recover, en1, en2;
  logic       vin_ok, v33_2v4, v33_ok, v5_ok, otemp, ov1, ov2, pg1, pg2, un1, un2;
  logic       z1, z2, ocl1, ocl2, nocl1, nocl2, ot1, ot2, pwm1, pwm2, above_sw;
  logic       l33, l5, l5_on, swo, l33_ch1, pump, pg, dis1, dis2, hs1, ls1, hs2, ls2;
  logic [9:0] ref1, ref2;
  int         errors, n_compared;

  dbes_top #(.ALWAYS_ON_5V(1'b0), .PG_DELAY(8), .UV_FILT(10), .UV_MASK(20), .SS_STEP(1),
    .PUMP_HALF(4)) dut_u (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .ce_i(ce),
    .ch1_enable_i(en1), .ch2_enable_i(en2), .vin_above_uvlo_i(vin_ok),
    .ldo_3v3_above_2v4_i(v33_2v4), .ldo_3v3_above_uvlo_i(v33_ok),
    .ldo_5v_above_uvlo_i(v5_ok), .over_temp_i(otemp), .ch1_over_i(ov1), .ch2_over_i(ov2),
    .ch1_above_pg_i(pg1), .ch2_above_pg_i(pg2), .ch1_under_i(un1), .ch2_under_i(un2),
    .ch1_fb_zero_i(z1), .ch2_fb_zero_i(z2), .ch1_ocl_i(ocl1), .ch2_ocl_i(ocl2),
    .ch1_neg_ocl_i(nocl1), .ch2_neg_ocl_i(nocl2), .ch1_ontime_done_i(ot1),
    .ch2_ontime_done_i(ot2), .ch1_pwm_req_i(pwm1), .ch2_pwm_req_i(pwm2),
    .ch1_out_above_sw_i(above_sw), .ldo_3v3_en_o(l33), .ldo_5v_en_o(l5),
    .switchover_o(swo), .ldo_3v3_from_ch1_o(l33_ch1), .pump_clock_out_o(pump),
    .power_good_out_o(pg), .ch1_output_sense_dis_o(dis1), .ch2_switch_node_dis_o(dis2),
    .ch1_high_side_gate_o(hs1), .ch1_low_side_gate_o(ls1), .ch2_high_side_gate_o(hs2),
    .ch2_low_side_gate_o(ls2), .ch1_ref_code_o(ref1), .ch2_ref_code_o(ref2));

  // second variant shares every input; only its 5V regulator enable is watched
  dbes_top #(.ALWAYS_ON_5V(1'b1), .PG_DELAY(8), .UV_FILT(10), .UV_MASK(20), .SS_STEP(1),
    .PUMP_HALF(4)) dut_on_u (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .ce_i(ce),
    .ch1_enable_i(en1), .ch2_enable_i(en2), .vin_above_uvlo_i(vin_ok),
    .ldo_3v3_above_2v4_i(v33_2v4), .ldo_3v3_above_uvlo_i(v33_ok),
    .ldo_5v_above_uvlo_i(v5_ok), .over_temp_i(otemp), .ch1_over_i(ov1), .ch2_over_i(ov2),
    .ch1_above_pg_i(pg1), .ch2_above_pg_i(pg2), .ch1_under_i(un1), .ch2_under_i(un2),
    .ch1_fb_zero_i(z1), .ch2_fb_zero_i(z2), .ch1_ocl_i(ocl1), .ch2_ocl_i(ocl2),
    .ch1_neg_ocl_i(nocl1), .ch2_neg_ocl_i(nocl2), .ch1_ontime_done_i(ot1),
    .ch2_ontime_done_i(ot2), .ch1_pwm_req_i(pwm1), .ch2_pwm_req_i(pwm2),
    .ch1_out_above_sw_i(above_sw), .ldo_3v3_en_o(), .ldo_5v_en_o(l5_on),
    .switchover_o(), .ldo_3v3_from_ch1_o(), .pump_clock_out_o(), .power_good_out_o(),
    .ch1_output_sense_dis_o(), .ch2_switch_node_dis_o(), .ch1_high_side_gate_o(),
    .ch1_low_side_gate_o(), .ch2_high_side_gate_o(), .ch2_low_side_gate_o(),
    .ch1_ref_code_o(), .ch2_ref_code_o());

  dbes_host_model host_u (.ref_clk_i(ref_clk), .en1_req_i(en1_req), .en2_req_i(en2_req),
    .recover_i(recover), .power_good_i(pg), .ch1_enable_o(en1), .ch2_enable_o(en2),
    .pg_seen_o());

  // ----------------------------------------------------------------
  // clock, compare and helper tasks
  // ----------------------------------------------------------------
  always #2 ref_clk = ~ref_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // counts pump clock changes over n cycles
  task automatic pump_edges(input int n, output int tog);
    logic last;
    tog = 0;
    last = pump;
    repeat (n) begin
      @(negedge ref_clk);
      if (pump !== last) tog++;
      last = pump;
    end
  endtask

  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #80000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    int tog;
    ref_clk = 0; rst_b = 0; ce = 1; en1_req = 0; en2_req = 0; recover = 0;
    vin_ok = 1; v33_2v4 = 1; v33_ok = 1; v5_ok = 0; otemp = 0; ov1 = 0; ov2 = 0;
    pg1 = 1; pg2 = 1; un1 = 0; un2 = 0; z1 = 0; z2 = 0; ocl1 = 0; ocl2 = 0;
    nocl1 = 0; nocl2 = 0; ot1 = 0; ot2 = 0; pwm1 = 0; pwm2 = 0; above_sw = 0;
    errors = 0; n_compared = 0;
    cyc(20); rst_b = 1; cyc(10);
    chk(10'(l33), 10'h1, "3v3 on");
    chk(10'(l5_on), 10'h1, "5v always on");
    chk(10'(l5), 10'h0, "5v off no enable");
    chk(10'(pump), 10'h0, "pump idle");
    chk(10'({dis1, dis2}), 10'h3, "discharge");
    en1_req = 1; cyc(50);
    chk(10'(l5), 10'h1, "5v on with en1");
    chk(ref1, 10'h0, "no ramp in lockout");
    v5_ok = 1; pump_edges(40, tog);
    chk(10'(tog), 10'ha, "pump rate");
    chk(10'(dis1), 10'h0, "ch1 discharge off");
    cyc(1100);
    chk(ref1, 10'h3ff, "ch1 ref target");
    chk(ref2, 10'h0, "ch2 ref idle");
    chk(10'(pg), 10'h0, "pg needs both");
    above_sw = 1; cyc(8);
    chk(10'({swo, l33_ch1, l5}), 10'h6, "switchover on");
    ocl1 = 1; pwm1 = 1; cyc(10);
    chk(10'({swo, l5, hs1}), 10'h2, "ocl blocks");
    ocl1 = 0; cyc(8);
    chk(10'(hs1), 10'h1, "on pulse after ocl");
    pwm1 = 0; ot1 = 1; above_sw = 0; cyc(4); ot1 = 0;
    en1_req = 0; cyc(8); pump_edges(40, tog);
    chk(10'(tog), 10'h0, "pump stops");
    en1_req = 1; en2_req = 1; un2 = 1; cyc(16); un2 = 0; cyc(1100);
    chk(10'({pg, dis2}), 10'h2, "pg after masked under");
    ov2 = 1; cyc(8);
    chk(10'(pg), 10'h0, "pg drop over");
    chk(ref2, 10'h0, "ovp target zero");
    z2 = 1; cyc(8);
    chk(10'({hs2, ls2}), 10'h1, "ovp latch gates");
    ov2 = 0; z2 = 0; cyc(20);
    chk(10'({pg, hs2, ls2}), 10'h1, "ovp stays latched");
    recover = 1; cyc(10); recover = 0; cyc(1100);
    chk(10'(pg), 10'h1, "recovered");
    un1 = 1; cyc(3); un1 = 0; cyc(2);
    chk(10'(pg), 10'h0, "pg drop under");
    cyc(5);
    chk(10'({pg, dis1}), 10'h0, "pg delay restart");
    cyc(15);
    chk(10'(pg), 10'h1, "pg back");
    un1 = 1; cyc(30);
    chk(10'({hs1, ls1, hs2, ls2, dis1, dis2}), 10'h3, "uvp latch");
    un1 = 0; recover = 1; cyc(10); recover = 0; cyc(1100);
    chk(10'(pg), 10'h1, "uvp cleared");
    vin_ok = 0; cyc(8);
    chk(10'({pg, hs1, hs2}), 10'h0, "lockout");
    vin_ok = 1; cyc(1100);
    chk(10'(pg), 10'h1, "lockout released");
    otemp = 1; cyc(8);
    chk(10'({l33, l5, pg}), 10'h0, "over temp");
    pump_edges(20, tog);
    chk(10'(tog), 10'h0, "pump off hot");
    otemp = 0; cyc(1100);
    chk(10'({l33, pg}), 10'h3, "temp restart");
    pg1 = 0; cyc(8);
    chk(10'(pg), 10'h0, "pg needs ch1 above 90");
    pg1 = 1; ce = 0; pump_edges(20, tog);
    chk(10'(tog), 10'h0, "clock enable freezes pump");
    ce = 1; v33_2v4 = 0; cyc(8);
    chk(10'({l5, l5_on}), 10'h0, "5v off below 2v4");
    v33_2v4 = 1; v33_ok = 0; cyc(8);
    chk(ref1, 10'h0, "3v3 lockout");
    v33_ok = 1; cyc(1100);
    ov1 = 1; cyc(8);
    chk(10'({hs1, ls1}), 10'h1, "ch1 ovp low side");
    nocl1 = 1; cyc(8);
    chk(10'({hs1, ls1}), 10'h2, "ch1 ovp neg limit");
    nocl1 = 0; ot1 = 1; cyc(8);
    chk(10'({hs1, ls1}), 10'h1, "ch1 ovp on-time end");
    ot1 = 0; z1 = 1; cyc(8);
    chk(10'({hs1, ls1}), 10'h1, "ch1 ovp latched");
    ov1 = 0; z1 = 0; recover = 1; cyc(10); recover = 0; cyc(1100);
    ocl2 = 1; pwm2 = 1; cyc(10);
    chk(10'(hs2), 10'h0, "ch2 ocl blocks");
    ocl2 = 0; cyc(8);
    chk(10'(hs2), 10'h1, "ch2 on after ocl");
    pwm2 = 0; ot2 = 1; cyc(8);
    chk(10'({hs2, ls2}), 10'h1, "ch2 on-time end");
    ot2 = 0; ov2 = 1; cyc(8); nocl2 = 1; cyc(8);
    chk(10'({hs2, ls2}), 10'h2, "ch2 ovp neg limit");
    nocl2 = 0; ov2 = 0;
    end_sim();
  end
endmodule
